/* rtl/adcsq_pkg.sv */
package adcsq_pkg;

  localparam int unsigned PERIOD_W   = 22;
  localparam int unsigned SEQ_IDX_W  = 3;
  localparam int unsigned SETTLE_W   = 2;

  // register select codes on the setup write port
  localparam logic reg_sel_setup_one = 1'h0;
  localparam logic reg_sel_setup_two = 1'h1;

  // reset values of the two setup bytes
  localparam logic [7:0] setup_one_reset = 8'h0a;
  localparam logic [7:0] setup_two_reset = 8'h00;

  // calibration-mode codes
  localparam logic [1:0] cal_normal = 2'h0;
  localparam logic [1:0] cal_offset = 2'h1;
  localparam logic [1:0] cal_gain   = 2'h2;

  // sequence lengths
  localparam logic [SEQ_IDX_W-1:0] seq_len_single = 3'h5;
  localparam logic [SEQ_IDX_W-1:0] seq_len_differential_select   = 3'h3;
  localparam logic [SEQ_IDX_W-1:0] seq_len_cal    = 3'h2;

  // conversions before data is valid after a restart
  localparam logic [SETTLE_W-1:0] settle_sinc3 = 2'h3;
  localparam logic [SETTLE_W-1:0] settle_sinc1 = 2'h1;

  // master clock and output rates at modulator code 00
  localparam int unsigned master_clock_hz = 40_000_000;
  localparam int unsigned rate_sps [8] = '{20, 25, 100, 200, 50, 60, 300, 600};

  // conversion period in master clock cycles, index {clk_bit, filter_select}
  function automatic logic [PERIOD_W-1:0] base_period(input logic [2:0] idx);
    base_period = PERIOD_W'(master_clock_hz / rate_sps[idx]);
  endfunction : base_period

  typedef struct packed {
    logic       chan_select_hi;
    logic       chan_select_lo;
    logic       modulator_rate_hi;
    logic       modulator_rate_lo;
    logic       clk_bit;
    logic       filter_select_hi;
    logic       filter_select_lo;
    logic       fast_filter;
  } adcsq_setup_one_type;

  typedef struct packed {
    logic       sequence_enable;
    logic       cal_mode_hi;
    logic       cal_mode_lo;
    logic       input_buffer_enable;
    logic       differential_select;
    logic       burnout_current_enable;
    logic       excitation_enable;
    logic       clock_prescale_enable;
  } adcsq_setup_two_type;

  // channel codes presented to the analog multiplexer
  typedef enum logic [3:0] {
    CH_SE1      = 4'h0,
    CH_SE2      = 4'h1,
    CH_SE3      = 4'h2,
    CH_SE4      = 4'h3,
    CH_SE5      = 4'h4,
    CH_DIFF12   = 4'h5,
    CH_DIFF34   = 4'h6,
    CH_DIFF56   = 4'h7,
    CH_CAL_OFF  = 4'h8,
    CH_CAL_GAIN = 4'h9,
    CH_NONE     = 4'hf
  } adcsq_chan_type;

  typedef struct packed {
    adcsq_chan_type chan;
    logic [1:0]     tf_index;
  } adcsq_route_type;

  typedef enum logic [1:0] {
    ST_SETTLE = 2'b01,
    ST_RUN    = 2'b10
  } adcsq_fsm_type;

  typedef struct packed {
    adcsq_setup_one_type    setup_one;
    adcsq_setup_two_type    setup_two;
    adcsq_fsm_type          fsm;
    logic [SEQ_IDX_W-1:0]   seq_idx;
    logic [PERIOD_W-1:0]    period_cnt;
    logic [SETTLE_W-1:0]    settle_cnt;
    logic                   prescale_tog;
    adcsq_route_type        route;
    logic                   data_ready;
    logic                   filter_reset;
    logic                   conv_done;
    logic                   offset_cal;
    logic                   gain_cal;
    logic                   clock_tick;
  } adcsq_state_type;

endpackage : adcsq_pkg

/* rtl/adcsq_sequencer.sv */
`timescale 1ns/1ps

// Operation
// - sequencing on converts channels in order
// - sequencing off repeats the selected channel
// - codes 01/10 select offset/gain calibration pair
// - single calibration uses selected channel settings
// - unequal mode bits append offset then gain
// - differential bit picks five or three channels
// - scanned calibration uses third transfer register
// - buffer bit enables or bypasses input buffers
// - single-ended versus common, differential in pairs
// - burn-out bit connects test currents
// - excitation bit enables both current outputs
// - prescale bit halves the internal clock
// - filter and modulator codes set output rate
// - low filter codes give full-resolution rates
// - channel-select bits ignored while sequencing
// - active control change restarts filter, drops ready
module adcsq_sequencer #(
  parameter int unsigned RATE_SHIFT = 0
) (
  input  wire logic                     clk,
  input  wire logic                     reset_n,
  input  wire logic                     reg_write,
  input  wire logic                     reg_select,
  input  wire logic [7:0]               reg_wdata,
  input  wire logic                     data_read,
  output adcsq_pkg::adcsq_setup_one_type setup_one_q,
  output adcsq_pkg::adcsq_setup_two_type setup_two_q,
  output adcsq_pkg::adcsq_route_type     route,
  output logic                          offset_cal_input,
  output logic                          gain_cal_input,
  output logic                          input_buffer_enable,
  output logic                          burnout_current_enable,
  output logic                          excitation_out_a,
  output logic                          excitation_out_b,
  output logic                          internal_clock_tick,
  output logic                          data_ready,
  output logic                          filter_reset,
  output logic                          conv_done
);
  import adcsq_pkg::*;

  logic            rst_sync1_reg;
  logic            rst_sync2_reg;
  adcsq_state_type st_reg;
  adcsq_state_type st_next;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync1_reg <= 1'b0;
      rst_sync2_reg <= 1'b0;
    end else begin
      rst_sync1_reg <= 1'b1;
      rst_sync2_reg <= rst_sync1_reg;
    end
  end

  function automatic adcsq_route_type route_of(input adcsq_setup_one_type s1,
                                               input adcsq_setup_two_type s2,
                                               input logic [SEQ_IDX_W-1:0] idx);
    logic [1:0]           sel;
    logic [1:0]           cal;
    logic [SEQ_IDX_W-1:0] nsig;
    adcsq_route_type      r;
    sel  = {s1.chan_select_hi, s1.chan_select_lo};
    cal  = {s2.cal_mode_hi, s2.cal_mode_lo};
    nsig = s2.differential_select ? seq_len_differential_select : seq_len_single;
    r    = '{chan: CH_NONE, tf_index: 2'h0};
    if (s2.sequence_enable) begin
      // channel-select bits play no part here
      if (idx < nsig) begin
        if (s2.differential_select) begin
          r.chan     = adcsq_chan_type'(4'(CH_DIFF12) + 4'(idx));
          r.tf_index = 2'(idx);
        end else begin
          r.chan     = adcsq_chan_type'(4'(idx));
          r.tf_index = 2'(idx >> 1);
        end
      end else if (idx == nsig) begin
        r = '{chan: CH_CAL_OFF, tf_index: 2'h2};
      end else begin
        r = '{chan: CH_CAL_GAIN, tf_index: 2'h2};
      end
    end else begin
      if (s2.differential_select) begin
        r.chan     = (sel == 2'h3) ? CH_NONE : adcsq_chan_type'(4'(CH_DIFF12) + 4'(sel));
        r.tf_index = (sel == 2'h3) ? 2'h0 : sel;
      end else begin
        r.chan     = adcsq_chan_type'(4'(sel));
        r.tf_index = {1'b0, sel[1]};
      end
      // calibration pair keeps the selected channel's transfer settings
      case (cal)
        cal_offset: r.chan = CH_CAL_OFF;
        cal_gain:   r.chan = CH_CAL_GAIN;
        cal_normal: r.chan = r.chan;
        default:    r.chan = CH_NONE;
      endcase
    end
    return r;
  endfunction : route_of

  logic [PERIOD_W-1:0] period;
  logic [SEQ_IDX_W-1:0] seq_len;
  logic [SETTLE_W-1:0] settle_target;
  logic                tick;
  logic                restart;
  logic                ready_set;
  adcsq_setup_two_type wdata_two;

  always_comb begin
    st_next = st_reg;
    restart = 1'b0;
    ready_set = 1'b0;
    // output rate from clock, filter and modulator codes
    period = base_period({st_reg.setup_one.clk_bit, st_reg.setup_one.filter_select_hi,
                          st_reg.setup_one.filter_select_lo})
             >> ({st_reg.setup_one.modulator_rate_hi, st_reg.setup_one.modulator_rate_lo}
                 + RATE_SHIFT);
    if (period == '0) begin
      period = PERIOD_W'(1);
    end
    seq_len = (st_reg.setup_two.differential_select ? seq_len_differential_select : seq_len_single)
              + ((st_reg.setup_two.cal_mode_hi != st_reg.setup_two.cal_mode_lo)
                 ? seq_len_cal : 3'h0);
    settle_target = st_reg.setup_one.fast_filter ? settle_sinc1 : settle_sinc3;
    // divide-by-2 prescaler gates the internal clock path
    tick = !st_reg.setup_two.clock_prescale_enable || st_reg.prescale_tog;
    st_next.prescale_tog = st_reg.setup_two.clock_prescale_enable && !st_reg.prescale_tog;
    st_next.filter_reset = 1'b0;
    st_next.conv_done = 1'b0;

    if (reg_write) begin
      if (reg_select == reg_sel_setup_one) begin
        restart = (reg_wdata != st_reg.setup_one);
        st_next.setup_one = adcsq_setup_one_type'(reg_wdata);
      end else begin
        restart = (reg_wdata != st_reg.setup_two);
        st_next.setup_two = adcsq_setup_two_type'(reg_wdata);
      end
    end

    if (restart) begin
      st_next.data_ready   = 1'b0;
      st_next.filter_reset = 1'b1;
      st_next.period_cnt   = '0;
      st_next.settle_cnt   = '0;
      st_next.seq_idx      = '0;
      st_next.fsm          = ST_SETTLE;
    end else if (tick) begin
      if (st_reg.period_cnt >= period - PERIOD_W'(1)) begin
        st_next.period_cnt = '0;
        st_next.conv_done  = 1'b1;
        if (st_reg.setup_two.sequence_enable) begin
          st_next.seq_idx = (st_reg.seq_idx >= seq_len - 3'h1) ? '0
                            : st_reg.seq_idx + 3'h1;
        end else begin
          st_next.seq_idx = '0;
        end
        case (st_reg.fsm)
          ST_SETTLE: begin
            st_next.settle_cnt = st_reg.settle_cnt + 2'h1;
            if (st_reg.settle_cnt + 2'h1 >= settle_target) begin
              st_next.fsm = ST_RUN;
              ready_set = 1'b1;
            end
          end
          ST_RUN: begin
            ready_set = 1'b1;
          end
          default: begin
            st_next.fsm = ST_SETTLE;
          end
        endcase
      end else begin
        st_next.period_cnt = st_reg.period_cnt + PERIOD_W'(1);
      end
    end

    // a new result wins over a read that clears the flag
    if (ready_set) begin
      st_next.data_ready = 1'b1;
    end else if (data_read) begin
      st_next.data_ready = 1'b0;
    end

    st_next.route = route_of(st_next.setup_one, st_next.setup_two, st_next.seq_idx);
    st_next.offset_cal = (st_next.route.chan == CH_CAL_OFF);
    st_next.gain_cal   = (st_next.route.chan == CH_CAL_GAIN);
    st_next.clock_tick = !st_next.setup_two.clock_prescale_enable || st_next.prescale_tog;
  end

  always_ff @(posedge clk or negedge rst_sync2_reg) begin
    if (!rst_sync2_reg) begin
      st_reg <= '{setup_one: setup_one_reset, setup_two: setup_two_reset, fsm: ST_SETTLE,
                  seq_idx: '0, period_cnt: '0, settle_cnt: '0, prescale_tog: 1'b0,
                  route: '{chan: CH_SE1, tf_index: 2'h0}, data_ready: 1'b0,
                  filter_reset: 1'b0, conv_done: 1'b0, offset_cal: 1'b0, gain_cal: 1'b0,
                  clock_tick: 1'b1};
    end else begin
      st_reg <= st_next;
    end
  end

  // output pins straight from the state register
  assign setup_one_q            = st_reg.setup_one;
  assign setup_two_q            = st_reg.setup_two;
  assign route                  = st_reg.route;
  assign offset_cal_input       = st_reg.offset_cal;
  assign gain_cal_input         = st_reg.gain_cal;
  assign input_buffer_enable    = st_reg.setup_two.input_buffer_enable;
  assign burnout_current_enable = st_reg.setup_two.burnout_current_enable;
  assign excitation_out_a       = st_reg.setup_two.excitation_enable;
  assign excitation_out_b       = st_reg.setup_two.excitation_enable;
  assign internal_clock_tick    = st_reg.clock_tick;
  assign data_ready             = st_reg.data_ready;
  assign filter_reset           = st_reg.filter_reset;
  assign conv_done              = st_reg.conv_done;
  // write byte seen as the second setup byte, for the checks below
  assign wdata_two              = adcsq_setup_two_type'(reg_wdata);

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_sync2_reg);

  restart_drops_ready_a: assert property (
    reg_write && restart |=> !data_ready && filter_reset)
    else $error("control change did not restart the filter");

  restart_resets_seq_a: assert property (
    filter_reset |-> st_reg.seq_idx == '0 && st_reg.fsm == ST_SETTLE)
    else $error("restart did not clear the sequence");

  seq_wraps_a: assert property (
    conv_done && setup_two_q.sequence_enable && $past(st_reg.seq_idx) == seq_len - 3'h1
    && !$past(restart) |-> st_reg.seq_idx == '0)
    else $error("sequence did not wrap");

  scan_cal_tf_a: assert property (
    setup_two_q.sequence_enable && (offset_cal_input || gain_cal_input)
    |-> route.tf_index == 2'h2)
    else $error("scanned calibration not on third transfer register");

  single_cal_sel_a: assert property (
    !setup_two_q.sequence_enable && {setup_two_q.cal_mode_hi, setup_two_q.cal_mode_lo}
    == cal_offset |-> route.chan == CH_CAL_OFF)
    else $error("offset calibration pair not selected");

  single_hold_a: assert property (
    !setup_two_q.sequence_enable && $stable(setup_one_q) && $stable(setup_two_q)
    |-> $stable(route))
    else $error("single channel mode changed channel");

  excite_both_a: assert property (
    reg_write && reg_select == reg_sel_setup_two
    |=> excitation_out_a == $past(wdata_two.excitation_enable)
        && excitation_out_b == $past(wdata_two.excitation_enable))
    else $error("excitation outputs disagree with control");

  prescale_tick_a: assert property (
    setup_two_q.clock_prescale_enable && internal_clock_tick
    ##1 setup_two_q.clock_prescale_enable |-> !internal_clock_tick)
    else $error("prescaler did not halve the clock");

  ready_after_settle_a: assert property (
    $rose(data_ready) |-> st_reg.fsm == ST_RUN && conv_done)
    else $error("data ready before settling finished");

  scan_order_a: assert property (
    conv_done && setup_two_q.sequence_enable && !$past(restart) && $past(st_reg.seq_idx)
    < seq_len - 3'h1 |-> st_reg.seq_idx == $past(st_reg.seq_idx) + 3'h1)
    else $error("sequence did not advance by one");

  single_gain_sel_a: assert property (
    !setup_two_q.sequence_enable && {setup_two_q.cal_mode_hi, setup_two_q.cal_mode_lo}
    == cal_gain |-> gain_cal_input && !offset_cal_input)
    else $error("gain calibration pair not selected");

  buffer_follow_a: assert property (
    reg_write && reg_select == reg_sel_setup_two
    |=> input_buffer_enable == $past(wdata_two.input_buffer_enable))
    else $error("input buffer control not applied");

  burnout_follow_a: assert property (
    reg_write && reg_select == reg_sel_setup_two
    |=> burnout_current_enable == $past(wdata_two.burnout_current_enable))
    else $error("burn-out current control not applied");

  read_clears_a: assert property (
    data_read && !ready_set |=> !data_ready)
    else $error("read did not clear data ready");

  single_repeat_a: assert property (
    !setup_two_q.sequence_enable |-> st_reg.seq_idx == '0)
    else $error("single channel mode left the first entry");

  scan_cal_cov: cover property (setup_two_q.sequence_enable && gain_cal_input ##1 conv_done);
  wrap_cov:     cover property (setup_two_q.sequence_enable && conv_done && route.chan == CH_SE1);
  ready_cov:    cover property ($rose(data_ready));
  restart_cov:  cover property (filter_reset ##[1:20] conv_done);
  single_cov:   cover property (!setup_two_q.sequence_enable && gain_cal_input ##1 conv_done);

endmodule : adcsq_sequencer

/* test/adcsq_host_model.sv */
`timescale 1ns/1ps
module adcsq_host_model (
  input  wire logic       clk,
  output logic            reg_write,
  output logic            reg_select,
  output logic [7:0]      reg_wdata,
  output logic            data_read
);
  initial begin
    reg_write = 1'b0;
    reg_select = 1'b0;
    reg_wdata = 8'h00;
    data_read = 1'b0;
  end
  // one setup byte per call unless a setup two byte carries calibration code 11, strobe high across exactly one edge
  task automatic write_reg(input logic sel, input logic [7:0] data);
    if (sel && data[6:5] == 2'h3) return;
    @(posedge clk);
    reg_write <= 1'b1;
    reg_select <= sel;
    reg_wdata <= data;
    @(posedge clk);
    reg_write <= 1'b0;
    reg_wdata <= ~data;
  endtask : write_reg
  task automatic read_data();
    @(posedge clk);
    data_read <= 1'b1;
    @(posedge clk);
    data_read <= 1'b0;
  endtask : read_data
endmodule : adcsq_host_model

/* test/adc_channel_sequencer_config_test.sv */
`timescale 1ns/1ps
module adc_channel_sequencer_config_test;
  import adcsq_pkg::*;
  localparam int unsigned SHIFT = 16;
  logic                clk;
  logic                reset_n;
  logic                reg_write;
  logic                reg_select;
  logic [7:0]          reg_wdata;
  logic                data_read;
  adcsq_setup_one_type setup_one_q;
  adcsq_setup_two_type setup_two_q;
  adcsq_route_type     route;
  logic                offset_cal_input;
  logic                gain_cal_input;
  logic [3:0]          pins;
  logic                internal_clock_tick;
  logic                data_ready;
  logic                filter_reset;
  logic                conv_done;
  int unsigned         num_errors = 0;
  int unsigned         checked = 0;
  int unsigned         cycles = 0;
  // expected {chan, tf_index} per scan step
  logic [5:0] seq_se [8] = '{6'h00, 6'h04, 6'h09, 6'h0d, 6'h12, 6'h22, 6'h26, 6'h00};
  logic [5:0] seq_df [8] = '{6'h14, 6'h19, 6'h1e, 6'h22, 6'h26, 6'h14, 6'h00, 6'h00};

  adcsq_sequencer #(.RATE_SHIFT(SHIFT)) adcsq_sequencer_inst (
    .clk(clk), .reset_n(reset_n), .reg_write(reg_write), .reg_select(reg_select),
    .reg_wdata(reg_wdata), .data_read(data_read), .setup_one_q(setup_one_q),
    .setup_two_q(setup_two_q), .route(route), .offset_cal_input(offset_cal_input),
    .gain_cal_input(gain_cal_input), .input_buffer_enable(pins[3]),
    .burnout_current_enable(pins[2]), .excitation_out_a(pins[1]),
    .excitation_out_b(pins[0]), .internal_clock_tick(internal_clock_tick),
    .data_ready(data_ready), .filter_reset(filter_reset), .conv_done(conv_done)
  );
  adcsq_host_model adcsq_host_model_inst (
    .clk(clk), .reg_write(reg_write), .reg_select(reg_select),
    .reg_wdata(reg_wdata), .data_read(data_read)
  );

  initial clk = 1'b0;
  always #12.5 clk = ~clk;

  task automatic report_and_stop();
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      report_and_stop();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] expv);
    checked++;
    if (seen !== expv) begin
      num_errors++;
      $display("[FAIL] %0t seen %0h expected %0h", $time, seen, expv);
    end
  endtask : check

  task automatic wr(input logic s, input logic [7:0] d);
    adcsq_host_model_inst.write_reg(s, d);
    #1;
  endtask : wr

  task automatic wait_change();
    logic [5:0] prev;
    prev = route;
    for (int n = 0; n < 100 && route === prev; n++) begin
      @(posedge clk);
      #1;
    end
  endtask : wait_change

  task automatic next_done(output int unsigned cyc);
    cyc = 0;
    do begin
      @(posedge clk);
      #1;
      cyc++;
    end while (conv_done !== 1'b1 && cyc < 5000);
  endtask : next_done

  task automatic scan_walk(input logic [7:0] s2, input int len, input logic [5:0] seq [8]);
    wr(1'b1, s2);
    @(posedge clk);
    #1;
    check(route, seq[0]);
    for (int i = 1; i < len; i++) begin
      wait_change();
      check(route, seq[i]);
    end
  endtask : scan_walk

  initial begin
    logic [3:0]  ec;
    logic [1:0]  et;
    int unsigned p;
    int unsigned n;
    int unsigned mf;
    logic        tk;
    reset_n = 1'b0;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    check(setup_one_q, setup_one_reset);
    check(setup_two_q, setup_two_reset);
    check({route, pins, data_ready, internal_clock_tick}, 12'h001);
    // buffer, burn-out and excitation on, then same byte again
    wr(1'b1, 8'h16);
    check({filter_reset, data_ready, pins}, 6'h2f);
    wr(1'b1, 8'h16);
    check(filter_reset, 1'b0);
    // single-channel selection over calibration codes 00 to 10, skipping differential channel-select code 3
    for (int d = 0; d < 2; d++)
      for (int a = 0; a < 4; a++)
        for (int m = 0; m < 3; m++) begin
          if (d == 1 && a == 3) continue;
          wr(1'b0, {a[1:0], 6'h0a});
          wr(1'b1, {1'b0, m[1:0], 1'b0, d[0], 3'h0});
          @(posedge clk);
          #1;
          ec = m == 1 ? CH_CAL_OFF : m == 2 ? CH_CAL_GAIN : 4'(d * 5 + a);
          et = d == 1 ? 2'(a) : 2'(a / 2);
          check({route, offset_cal_input, gain_cal_input, pins},
                {ec, et, m == 1, m == 2, 4'h0});
        end
    // scanning with channel-select bits set to 3
    wr(1'b0, 8'hcb);
    scan_walk(8'ha0, 8, seq_se);
    scan_walk(8'hc8, 6, seq_df);
    // settled data after restart in three-sample filter mode
    wr(1'b1, 8'h00);
    wr(1'b0, 8'h0a);
    n = 0;
    for (int i = 0; i < 200 && data_ready !== 1'b1; i++) begin
      @(posedge clk);
      #1;
      if (conv_done === 1'b1) n++;
    end
    check(n, 3);
    adcsq_host_model_inst.read_data();
    #1;
    check(data_ready, 1'b0);
    // conversion periods over clock, filter and modulator codes, once prescaled
    for (int k = 0; k < 11; k++) begin
      mf = k < 8 ? 0 : k - 7;
      wr(1'b1, {7'h00, k == 8});
      wr(1'b0, {2'h0, mf[1:0], k[2:0], 1'b1});
      p = (master_clock_hz / rate_sps[k % 8]) >> (SHIFT + mf);
      if (p == 0) p = 1;
      if (k == 8) p = p * 2;
      next_done(n);
      check(data_ready, 1'b1);
      next_done(n);
      check(n, p);
      if (k == 8) begin
        tk = internal_clock_tick;
        @(posedge clk);
        #1;
        check(internal_clock_tick, !tk);
      end
    end
    report_and_stop();
  end
endmodule : adc_channel_sequencer_config_test
